// *** logic/counter_shift_pkg.sv ***
package counter_shift_pkg;

    // Width of the counter / shift state
    localparam int unsigned STATE_W = 4;

    // Mode select codes (mode_select[2:0], msb first)
    localparam logic [2:0] MODE_PRESET     = 3'h0;
    localparam logic [2:0] MODE_INVERT     = 3'h1;
    localparam logic [2:0] MODE_SHIFT_DOWN = 3'h2;  // Toward bit 0
    localparam logic [2:0] MODE_SHIFT_UP   = 3'h3;  // Toward bit 3
    localparam logic [2:0] MODE_COUNT_DOWN = 3'h4;
    localparam logic [2:0] MODE_CLEAR      = 3'h5;
    localparam logic [2:0] MODE_COUNT_UP   = 3'h6;
    localparam logic [2:0] MODE_HOLD       = 3'h7;

    // End-of-range values and step
    localparam logic [3:0] STATE_ZERO = 4'h0;
    localparam logic [3:0] STATE_MAX  = 4'hF;
    localparam logic [3:0] STATE_STEP = 4'h1;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFFSET_CONTROL = 8'h00;
    localparam logic [7:0] OFFSET_STATUS  = 8'h04;
    localparam int unsigned ADDR_DECODE_W = 8;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_TC_BIT    = 4;

    // Reset values
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

    // Control register image
    typedef struct packed {
        logic run_enable;   // 0 freezes the state, as hold
    } control_t;

    // Status register image
    typedef struct packed {
        logic       tc_n;
        logic [3:0] state;
    } status_t;

endpackage

// *** logic/counter_shift.sv ***
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module counter_shift (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        async_master_clear,
    input  wire logic [2:0]  mode_select,
    input  wire logic [3:0]  parallel_preset_in,
    input  wire logic        parallel_count_enable_n,
    input  wire logic        serial_in_trickle_enable_n,
    input  wire logic        high_end_serial_in,
    output logic      [3:0]  state_out,
    output logic      [3:0]  state_out_n,
    output logic             terminal_count_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Usage notes
    //
    // Clock: hclk is also the counter clock, so every state step lands on a
    // rising hclk edge and the bus and the core share one timing domain.
    //
    // Pin inputs: mode_select, the enables, the presets and both serial inputs
    // are read raw. They come from neighbouring stages on the same clock, and
    // a synchroniser would cost the one-cycle carry that chaining relies on.
    // A user who drives them from another clock must synchronise outside.
    //
    // Terminal count: a combinational level. It follows mode_select, the
    // trickle pin and the state within the cycle, so a chain of stages forms
    // a ripple path; a long chain limits the clock rate accordingly.
    //
    // Master clear: acts without the clock and wins over everything, the bus
    // reset included. Stepping resumes at the first rising edge after it falls.
    // The control register is not touched by it, only the counter state.
    //
    // Register map, one aligned word each:
    //   Control, offset 0x00: bit 0 run enable, reset 1. Low freezes the state
    //     as in hold, while the terminal count still decodes the selected mode.
    //   Status, offset 0x04: bits 3..0 state, bit 4 terminal count (active
    //     low). Read only; writes to it are dropped.
    //   Any other value of haddr[7:0] reads zero and ignores writes; higher address bits are not decoded.
    //
    // Bus timing: zero wait states, response always OKAY. Read data is taken
    // at the address-phase edge, so a read shows the state as it stood at
    // that edge, not at the end of the data phase. A write lands at the edge
    // that ends its data phase. Back-to-back transfers are accepted.
    //
    // Limitation: hsize is not checked; only whole-word access is meaningful,
    // and a narrower write still updates the run enable from bit 0.
    //
    // Trade-off: run enable sits in front of the mode decode rather than in
    // the clock path, which keeps one clock and no gating on the state flops.

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [3:0]                 next_state;      // Value taken at next edge
    logic                       count_go;        // Both enables low
    counter_shift_pkg::control_t control;        // Software control
    counter_shift_pkg::status_t  status;         // Live status image
    logic                       dphase_valid;    // Data phase pending
    logic                       dphase_write;    // Pending is a write
    logic [7:0]                 dphase_addr;     // Pending byte offset

    ////////////////////////////////////////////////////////////////////////////
    // Counter / shifter core

    // Counting only when parallel and trickle enables are both low
    assign count_go = !parallel_count_enable_n && !serial_in_trickle_enable_n;

    // Next-state selection per mode
    always_comb
    begin
        next_state = state_out;
        if (control.run_enable)
        begin
            case (mode_select)
                counter_shift_pkg::MODE_PRESET:
                    next_state = parallel_preset_in;
                counter_shift_pkg::MODE_INVERT:
                    next_state = ~state_out;
                counter_shift_pkg::MODE_SHIFT_DOWN:
                    next_state = {high_end_serial_in, state_out[3:1]};
                counter_shift_pkg::MODE_SHIFT_UP:
                    next_state = {state_out[2:0], serial_in_trickle_enable_n};
                counter_shift_pkg::MODE_COUNT_DOWN:
                    // Disabled count just holds
                    next_state = count_go ? state_out - counter_shift_pkg::STATE_STEP
                                          : state_out;
                counter_shift_pkg::MODE_CLEAR:
                    next_state = counter_shift_pkg::STATE_ZERO;
                counter_shift_pkg::MODE_COUNT_UP:
                    next_state = count_go ? state_out + counter_shift_pkg::STATE_STEP
                                          : state_out;
                counter_shift_pkg::MODE_HOLD:
                    next_state = state_out;
                default:
                    next_state = state_out;
            endcase
        end
    end

    // State register; master clear acts without the clock and wins
    always_ff @(posedge hclk or negedge hresetn or posedge async_master_clear)
    begin
        if (!hresetn || async_master_clear)
            state_out <= counter_shift_pkg::STATE_ZERO;
        else
            state_out <= next_state;
    end

    // Complement outputs
    assign state_out_n = ~state_out;

    // Terminal count decode; combinational so cascaded stages see it
    // within the same cycle, which the chaining depends on
    always_comb
    begin
        case (mode_select)
            counter_shift_pkg::MODE_PRESET,
            counter_shift_pkg::MODE_INVERT:
                terminal_count_n = 1'b0;
            counter_shift_pkg::MODE_SHIFT_DOWN:
                terminal_count_n = high_end_serial_in;
            counter_shift_pkg::MODE_SHIFT_UP:
                terminal_count_n = state_out[3];
            counter_shift_pkg::MODE_COUNT_DOWN:
                // Parallel enable does not affect the decode
                terminal_count_n = serial_in_trickle_enable_n ||
                    (state_out != counter_shift_pkg::STATE_ZERO);
            counter_shift_pkg::MODE_COUNT_UP:
                terminal_count_n = serial_in_trickle_enable_n ||
                    (state_out != counter_shift_pkg::STATE_MAX);
            counter_shift_pkg::MODE_CLEAR,
            counter_shift_pkg::MODE_HOLD:
                terminal_count_n = 1'b1;
            default:
                terminal_count_n = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Live status image for reads
    assign status.state = state_out;
    assign status.tc_n  = terminal_count_n;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dphase_valid <= 1'b0;
            dphase_write <= 1'b0;
            dphase_addr  <= 8'h00;
        end
        else if (hready)
        begin
            // Only NONSEQ/SEQ start a transfer; IDLE/BUSY ignored
            dphase_valid <= hsel && htrans[1];
            dphase_write <= hwrite;
            dphase_addr  <= haddr[counter_shift_pkg::ADDR_DECODE_W-1:0];
        end
    end

    // Control register write in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            control.run_enable <= counter_shift_pkg::CONTROL_RESET[counter_shift_pkg::CTRL_RUN_BIT];
        else if (dphase_valid && dphase_write &&
                 dphase_addr == counter_shift_pkg::OFFSET_CONTROL)
            control.run_enable <= hwdata[counter_shift_pkg::CTRL_RUN_BIT];
    end

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[counter_shift_pkg::ADDR_DECODE_W-1:0])
                counter_shift_pkg::OFFSET_CONTROL:
                    hrdata <= {31'h0000_0000, control.run_enable};
                counter_shift_pkg::OFFSET_STATUS:
                    hrdata <= {27'h000_0000, status};
                default:
                    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || async_master_clear);

    // Stepping is possible in this cycle
    sequence run_in(logic [2:0] m);
        control.run_enable && mode_select == m;
    endsequence

    // Either counting mode selected; the decode bit pattern 1x0
    sequence count_mode;
        mode_select[2] && !mode_select[0];
    endsequence

    // Two shift-up steps in a row
    sequence two_shift_up;
        run_in(counter_shift_pkg::MODE_SHIFT_UP) ##1 run_in(counter_shift_pkg::MODE_SHIFT_UP);
    endsequence

    a_preset_load: assert property (
        run_in(counter_shift_pkg::MODE_PRESET) |=> state_out == $past(parallel_preset_in)
    ) else $error("preset not loaded");

    a_invert_bits: assert property (
        run_in(counter_shift_pkg::MODE_INVERT) |=> state_out == ~$past(state_out)
    ) else $error("invert wrong");

    a_shift_down: assert property (
        run_in(counter_shift_pkg::MODE_SHIFT_DOWN)
        |=> state_out == {$past(high_end_serial_in), $past(state_out[3:1])}
    ) else $error("shift down wrong");

    a_shift_up: assert property (
        run_in(counter_shift_pkg::MODE_SHIFT_UP)
        |=> state_out == {$past(state_out[2:0]), $past(serial_in_trickle_enable_n)}
    ) else $error("shift up wrong");

    a_shift_up_tc: assert property (
        two_shift_up |-> terminal_count_n == $past(state_out[2])
    ) else $error("shift up terminal count wrong");

    a_count_down: assert property (
        run_in(counter_shift_pkg::MODE_COUNT_DOWN) ##0 count_go
        |=> state_out == $past(state_out) - counter_shift_pkg::STATE_STEP
    ) else $error("count down wrong");

    a_count_up: assert property (
        run_in(counter_shift_pkg::MODE_COUNT_UP) ##0 count_go
        |=> state_out == $past(state_out) + counter_shift_pkg::STATE_STEP
    ) else $error("count up wrong");

    a_count_disabled: assert property (
        mode_select[2] && !mode_select[0] && parallel_count_enable_n
        |=> $stable(state_out)
    ) else $error("disabled count moved");

    a_trickle_off: assert property (
        mode_select[2] && !mode_select[0] && serial_in_trickle_enable_n
        |-> terminal_count_n ##1 $stable(state_out)
    ) else $error("trickle-off behaviour wrong");

    a_tc_end_up: assert property (
        mode_select == counter_shift_pkg::MODE_COUNT_UP && !serial_in_trickle_enable_n
        |-> terminal_count_n == (state_out != counter_shift_pkg::STATE_MAX)
    ) else $error("up terminal count wrong");

    a_clear_state: assert property (
        run_in(counter_shift_pkg::MODE_CLEAR)
        |-> terminal_count_n ##1 state_out == counter_shift_pkg::STATE_ZERO
    ) else $error("clear wrong");

    a_hold_state: assert property (
        mode_select == counter_shift_pkg::MODE_HOLD |-> terminal_count_n ##1 $stable(state_out)
    ) else $error("hold wrong");

    a_master_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        async_master_clear |-> state_out == counter_shift_pkg::STATE_ZERO
    ) else $error("master clear not applied");

    a_complement_out: assert property (
        state_out_n == ~state_out
    ) else $error("complement mismatch");

    // Count-down end of range decodes at zero
    a_tc_end_down: assert property (
        mode_select == counter_shift_pkg::MODE_COUNT_DOWN && !serial_in_trickle_enable_n
        |-> terminal_count_n == (state_out != counter_shift_pkg::STATE_ZERO)
    ) else $error("down terminal count wrong");

    // Stopped by software: no step at all, whatever the mode
    a_run_freeze: assert property (
        !control.run_enable |=> $stable(state_out)
    ) else $error("frozen state moved");

    // Preset mode drives terminal count low
    a_preset_tc: assert property (
        mode_select == counter_shift_pkg::MODE_PRESET |-> !terminal_count_n
    ) else $error("preset terminal count wrong");

    // Invert mode drives terminal count low as well
    a_invert_tc: assert property (
        mode_select == counter_shift_pkg::MODE_INVERT |-> !terminal_count_n
    ) else $error("invert terminal count wrong");

    // Shifting down, terminal count repeats the high-end serial input
    a_shift_down_tc: assert property (
        mode_select == counter_shift_pkg::MODE_SHIFT_DOWN
        |-> terminal_count_n == high_end_serial_in
    ) else $error("shift down terminal count wrong");

    // Shifting up, terminal count repeats the top bit
    a_shift_up_q3: assert property (
        mode_select == counter_shift_pkg::MODE_SHIFT_UP |-> terminal_count_n == state_out[3]
    ) else $error("shift up top bit wrong");

    // Counting steps only with both active-low enables asserted
    a_count_both_en: assert property (
        count_mode ##0 !count_go |=> $stable(state_out)
    ) else $error("count without both enables");

    // Status read returns the state seen at the address edge
    a_status_read: assert property (
        hready && hsel && htrans[1] && !hwrite &&
        haddr[counter_shift_pkg::ADDR_DECODE_W-1:0] == counter_shift_pkg::OFFSET_STATUS
        |=> hrdata[3:0] == $past(state_out)
    ) else $error("status read wrong");

    // Complement outputs all high while master clear holds the state
    a_clear_complement: assert property (
        @(posedge hclk) disable iff (!hresetn)
        async_master_clear |-> state_out_n == ~counter_shift_pkg::STATE_ZERO
    ) else $error("complement during clear wrong");

endmodule

// *** sim/lower_stage_model.sv ***
`timescale 1ns/1ps
// Lower counter stage whose terminal count feeds the block's trickle input
module lower_stage_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tc_n
);
    logic [3:0] count; // Running value of the lower stage

    // Counts up only while enabled, wraps at the top of range
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= 4'h0;
        else if (run)
            count <= count + 4'h1;
    end

    // Low at the top carries one step into the next stage
    assign tc_n = !(run && count == 4'hF);
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        hclk;
    logic        hresetn;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        async_master_clear;
    logic [2:0]  mode_select;
    logic [3:0]  parallel_preset_in;
    logic        parallel_count_enable_n;
    logic        trickle_level; // Trickle level when no lower stage
    logic        serial_in_trickle_enable_n;
    logic        high_end_serial_in;
    logic [3:0]  state_out;
    logic [3:0]  state_out_n;
    logic        terminal_count_n;
    logic        use_lower;  // Chain the lower stage in
    logic        lower_tc_n;
    logic [3:0]  q;          // Expected state
    logic        run;        // Expected run enable
    logic [31:0] rd;
    int          err_count;
    int          checks_done;

    // Trickle pin comes from the lower stage only while chained
    assign serial_in_trickle_enable_n = use_lower ? lower_tc_n : trickle_level;

    counter_shift u_counter_shift (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .async_master_clear(async_master_clear), .mode_select(mode_select),
        .parallel_preset_in(parallel_preset_in),
        .parallel_count_enable_n(parallel_count_enable_n),
        .serial_in_trickle_enable_n(serial_in_trickle_enable_n),
        .high_end_serial_in(high_end_serial_in), .state_out(state_out),
        .state_out_n(state_out_n), .terminal_count_n(terminal_count_n));

    lower_stage_model u_lower_stage_model (.clk(hclk), .rst_n(hresetn), .run(use_lower),
        .tc_n(lower_tc_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 25 ns
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // Bounded wait for ready; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n == 50)
        begin
            err_count++;
            final_report();
        end
    endtask

    // One single AHB transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {htrans, haddr, hwrite} <= {2'h2, a, wr};
        wait_rdy();
        {htrans, hwdata} <= {2'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    // Drive one mode step, check outputs of the previous step, advance model
    task automatic op(input logic [2:0] m, input logic [3:0] p, input logic ep,
                      input logic et, input logic d);
        logic t;
        @(posedge hclk);
        {mode_select, parallel_preset_in, parallel_count_enable_n, trickle_level,
         high_end_serial_in} <= {m, p, ep, et, d};
        @(negedge hclk);
        case (m)
            3'h0, 3'h1: t = 1'b0;
            3'h2: t = d;
            3'h3: t = q[3];
            3'h4: t = et | (q != 4'h0);
            3'h6: t = et | (q != 4'hF);
            default: t = 1'b1;
        endcase
        chk("state_out", {28'h0, q}, {28'h0, state_out});
        chk("state_out_n", {28'h0, ~q}, {28'h0, state_out_n});
        chk("terminal_count_n", {31'h0, t}, {31'h0, terminal_count_n});
        if (run)
            case (m)
                3'h0: q = p;
                3'h1: q = ~q;
                3'h2: q = {d, q[3:1]};
                3'h3: q = {q[2:0], et};
                3'h4: q = (!ep && !et) ? q - 4'h1 : q;
                3'h5: q = 4'h0;
                3'h6: q = (!ep && !et) ? q + 4'h1 : q;
                default: q = q;
            endcase
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {hresetn, async_master_clear, htrans, haddr, hwrite, hwdata} = '0;
        {mode_select, parallel_preset_in, parallel_count_enable_n, trickle_level,
         high_end_serial_in, use_lower} = {3'h7, 4'h0, 4'hE};
        {q, run, err_count, checks_done} = '0;
        run = 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        chk("control", 32'h1, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        op(3'h0, 4'hE, 1, 1, 0);
        op(3'h6, 4'h0, 0, 0, 0);
        op(3'h6, 4'h0, 1, 0, 0);
        op(3'h6, 4'h0, 0, 1, 0);
        op(3'h6, 4'h0, 0, 0, 0);
        op(3'h4, 4'h0, 0, 0, 0);
        op(3'h4, 4'h0, 1, 0, 0);
        op(3'h4, 4'h0, 1, 1, 0);
        op(3'h1, 4'h0, 1, 1, 0);
        op(3'h0, 4'h6, 0, 0, 0);
        op(3'h2, 4'h0, 0, 0, 1);
        op(3'h2, 4'h0, 0, 0, 0);
        op(3'h3, 4'h0, 0, 1, 0);
        op(3'h3, 4'h0, 0, 0, 0);
        op(3'h3, 4'h0, 0, 0, 0);
        op(3'h5, 4'h0, 0, 0, 1);
        op(3'h7, 4'h0, 0, 0, 1);
        op(3'h7, 4'h0, 0, 0, 1);
        $display("test modes done");
        // Stopped counter still decodes terminal count
        ahb(1'b1, 32'h0, 32'h0);
        run = 1'b0;
        op(3'h6, 4'h0, 0, 0, 0);
        op(3'h7, 4'h0, 0, 0, 0);
        ahb(1'b0, 32'h4, 32'h0);
        chk("status", {27'h0, 1'b1, q}, rd);
        ahb(1'b0, 32'h8, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 32'h0, 32'h1);
        run = 1'b1;
        $display("test registers done");
        // Clear overrides a preset edge without waiting for the clock
        op(3'h0, 4'h9, 0, 0, 0);
        op(3'h0, 4'h9, 0, 0, 0);
        @(posedge hclk);
        async_master_clear <= 1'b1;
        #3 chk("cleared", 32'h0, {28'h0, state_out});
        @(posedge hclk);
        #3 chk("held clear", 32'h0, {28'h0, state_out});
        @(posedge hclk);
        async_master_clear <= 1'b0;
        q = 4'h9;
        op(3'h7, 4'h0, 0, 0, 0);
        $display("test clear done");
        // Two carries from the lower stage over 32 edges
        @(posedge hclk);
        {mode_select, parallel_count_enable_n, use_lower} <= {3'h6, 1'b0, 1'b1};
        repeat (32) @(posedge hclk);
        {mode_select, use_lower} <= {3'h7, 1'b0};
        q = q + 4'h2;
        op(3'h7, 4'h0, 0, 0, 0);
        $display("test cascade done");
        final_report();
    end
endmodule
